// file: inc/sprite_pivot_pkg.sv
package sprite_pivot_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned STRB_W        = DATA_W / 8;
    localparam int unsigned LANE_W        = 8;
    localparam int unsigned BYTE_PER_WORD = 4;

    // ------------------------------------------------------------------
    // Register map: printed offsets are indices, byte address is 4x
    // ------------------------------------------------------------------
    localparam logic [7:0]        IDX_PIVOT_X  = 8'h14;
    localparam logic [7:0]        IDX_PIVOT_Y  = 8'h16;
    localparam logic [ADDR_W-1:0] ADDR_PIVOT_X = ADDR_W'(IDX_PIVOT_X * BYTE_PER_WORD);
    localparam logic [ADDR_W-1:0] ADDR_PIVOT_Y = ADDR_W'(IDX_PIVOT_Y * BYTE_PER_WORD);

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned REG_W     = 16;
    localparam int unsigned REG_LANES = REG_W / LANE_W;
    localparam int unsigned MAG_W     = 11;
    localparam int unsigned SIGN_BIT  = 15;
    localparam int unsigned OFS_W     = MAG_W + 1;
    localparam int unsigned PIX_W     = 11;
    localparam int unsigned COORD_W   = 14;
    localparam int unsigned NUM_AXES  = 2;
    localparam int unsigned AXIS_X    = 0;
    localparam int unsigned AXIS_Y    = 1;

    localparam logic [REG_W-1:0] PIVOT_RESET = 16'h0000;

endpackage : sprite_pivot_pkg

// file: hdl/pivot_axis_reg.sv
`timescale 1ns/10ps
module pivot_axis_reg (
    input  wire logic                                     core_clk,
    input  wire logic                                     rstn,
    input  wire logic                                     ce,
    input  wire logic                                     wr_en,
    input  wire logic [sprite_pivot_pkg::REG_W-1:0]       wdata,
    input  wire logic [sprite_pivot_pkg::REG_LANES-1:0]   wstrb,
    output logic      [sprite_pivot_pkg::REG_W-1:0]       value,
    output logic signed [sprite_pivot_pkg::OFS_W-1:0]     offset,
    output logic                                          negative
);

    // ------------------------------------------------------------------
    // Byte-lane storage
    // ------------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < sprite_pivot_pkg::REG_LANES; lane++) begin : g_lane
            localparam int unsigned LO = lane * sprite_pivot_pkg::LANE_W;
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    value[LO +: sprite_pivot_pkg::LANE_W] <=
                        sprite_pivot_pkg::PIVOT_RESET[LO +: sprite_pivot_pkg::LANE_W];
                end else if (ce && wr_en && wstrb[lane]) begin
                    value[LO +: sprite_pivot_pkg::LANE_W] <= wdata[LO +: sprite_pivot_pkg::LANE_W];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // Bits 14..11 are stored for readback but never steer the engine
    assign negative = value[sprite_pivot_pkg::SIGN_BIT];
    assign offset   = {value[sprite_pivot_pkg::SIGN_BIT],
                       value[sprite_pivot_pkg::MAG_W-1:0]};

endmodule : pivot_axis_reg

// file: hdl/sprite_reference_point_regs.sv
// Function
// - Horizontal offset register keeps an 11-bit magnitude in bits 10..0.
// - Horizontal bits 15..11 are sign bits; only bit 15 marks negative.
// - Vertical offset register keeps an 11-bit magnitude in bits 10..0.
// - Vertical offset is negative when bit 15 is set; bits 14..11 ignored.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module sprite_reference_point_regs (
    input  wire logic                                       core_clk,
    input  wire logic                                       rstn,
    input  wire logic                                       ce,
    input  wire logic                                       psel,
    input  wire logic                                       penable,
    input  wire logic                                       pwrite,
    input  wire logic        [sprite_pivot_pkg::ADDR_W-1:0] paddr,
    input  wire logic        [sprite_pivot_pkg::DATA_W-1:0] pwdata,
    input  wire logic        [sprite_pivot_pkg::STRB_W-1:0] pstrb,
    output logic             [sprite_pivot_pkg::DATA_W-1:0] prdata,
    output logic                                            pready,
    output logic                                            pslverr,
    input  wire logic                                       px_valid,
    input  wire logic        [sprite_pivot_pkg::PIX_W-1:0]  px_x,
    input  wire logic        [sprite_pivot_pkg::PIX_W-1:0]  px_y,
    output logic                                            rel_valid,
    output logic signed      [sprite_pivot_pkg::COORD_W-1:0] rel_x,
    output logic signed      [sprite_pivot_pkg::COORD_W-1:0] rel_y,
    input  wire logic signed [sprite_pivot_pkg::COORD_W-1:0] ref_x,
    input  wire logic signed [sprite_pivot_pkg::COORD_W-1:0] ref_y,
    output logic signed      [sprite_pivot_pkg::COORD_W-1:0] corner_x,
    output logic signed      [sprite_pivot_pkg::COORD_W-1:0] corner_y,
    output logic signed      [sprite_pivot_pkg::OFS_W-1:0]  pivot_x,
    output logic signed      [sprite_pivot_pkg::OFS_W-1:0]  pivot_y,
    output logic                                            pivot_neg_x,
    output logic                                            pivot_neg_y
);

    localparam int unsigned NA = sprite_pivot_pkg::NUM_AXES;
    localparam int unsigned RW = sprite_pivot_pkg::REG_W;
    localparam int unsigned CW = sprite_pivot_pkg::COORD_W;
    localparam int unsigned PW = sprite_pivot_pkg::PIX_W;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [NA-1:0] decode_axis(input logic [sprite_pivot_pkg::ADDR_W-1:0] a);
        logic [NA-1:0] sel;
        sel = '0;
        if (a == sprite_pivot_pkg::ADDR_PIVOT_X) begin
            sel[sprite_pivot_pkg::AXIS_X] = 1'b1;
        end else if (a == sprite_pivot_pkg::ADDR_PIVOT_Y) begin
            sel[sprite_pivot_pkg::AXIS_Y] = 1'b1;
        end
        return sel;
    endfunction : decode_axis

    logic [NA-1:0]              axis_sel;
    logic                       hit;
    logic                       data_ready;
    logic                       complete;
    logic                       wr_take;
    logic [RW-1:0]              rd_word;
    logic [NA-1:0][RW-1:0]      pivot_reg;
    logic signed [NA-1:0][sprite_pivot_pkg::OFS_W-1:0] pivot_ofs;
    logic [NA-1:0]              pivot_neg;

    assign axis_sel = decode_axis(paddr);
    assign hit      = |axis_sel;
    // Wait states whenever ce is low, or was low in setup, so prdata is never stale
    assign pready   = psel && penable && data_ready && ce;
    assign complete = pready;
    assign pslverr  = complete && !hit;
    assign wr_take  = complete && pwrite && hit;
    assign rd_word  = axis_sel[sprite_pivot_pkg::AXIS_X] ? pivot_reg[sprite_pivot_pkg::AXIS_X] :
                      axis_sel[sprite_pivot_pkg::AXIS_Y] ? pivot_reg[sprite_pivot_pkg::AXIS_Y] :
                      '0;

    // ------------------------------------------------------------------
    // Read data and ready tracking
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_ready <= 1'b0;
            prdata     <= '0;
        end else if (ce) begin
            if (complete || !psel) begin
                data_ready <= 1'b0;
            end else if (!data_ready) begin
                data_ready <= 1'b1;
                // Upper half reads as zero; whole 16 bits read back as written
                prdata     <= {{(sprite_pivot_pkg::DATA_W-RW){1'b0}}, rd_word};
            end
        end
    end

    // ------------------------------------------------------------------
    // Offset registers
    // ------------------------------------------------------------------
    genvar ax;
    generate
        for (ax = 0; ax < NA; ax++) begin : g_axis
            pivot_axis_reg u_reg (
                .core_clk (core_clk),
                .rstn     (rstn),
                .ce       (ce),
                .wr_en    (wr_take && axis_sel[ax]),
                .wdata    (pwdata[RW-1:0]),
                .wstrb    (pstrb[sprite_pivot_pkg::REG_LANES-1:0]),
                .value    (pivot_reg[ax]),
                .offset   (pivot_ofs[ax]),
                .negative (pivot_neg[ax])
            );
        end
    endgenerate

    assign pivot_x     = pivot_ofs[sprite_pivot_pkg::AXIS_X];
    assign pivot_y     = pivot_ofs[sprite_pivot_pkg::AXIS_Y];
    assign pivot_neg_x = pivot_neg[sprite_pivot_pkg::AXIS_X];
    assign pivot_neg_y = pivot_neg[sprite_pivot_pkg::AXIS_Y];

    // ------------------------------------------------------------------
    // Transform centre and placement
    // ------------------------------------------------------------------
    logic signed [CW-1:0] ext_px_x;
    logic signed [CW-1:0] ext_px_y;
    logic signed [CW-1:0] ext_piv_x;
    logic signed [CW-1:0] ext_piv_y;
    logic signed [CW-1:0] next_rel_x;
    logic signed [CW-1:0] next_rel_y;
    logic signed [CW-1:0] next_corner_x;
    logic signed [CW-1:0] next_corner_y;

    assign ext_px_x      = signed'({{(CW-PW){1'b0}}, px_x});
    assign ext_px_y      = signed'({{(CW-PW){1'b0}}, px_y});
    assign ext_piv_x     = CW'(pivot_x);
    assign ext_piv_y     = CW'(pivot_y);
    // Pixel position seen from the pivot; rotate/mirror then acts about zero
    assign next_rel_x    = CW'(ext_px_x - ext_piv_x);
    assign next_rel_y    = CW'(ext_px_y - ext_piv_y);
    // No clamping: a pivot outside the sprite is legal, results wrap at CW bits
    assign next_corner_x = CW'(ref_x - ext_piv_x);
    assign next_corner_y = CW'(ref_y - ext_piv_y);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rel_valid <= 1'b0;
            rel_x     <= '0;
            rel_y     <= '0;
            corner_x  <= '0;
            corner_y  <= '0;
        end else if (ce) begin
            rel_valid <= px_valid;
            if (px_valid) begin
                rel_x <= next_rel_x;
                rel_y <= next_rel_y;
            end
            corner_x  <= next_corner_x;
            corner_y  <= next_corner_y;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_write_x;
        (complete && pwrite && axis_sel[sprite_pivot_pkg::AXIS_X] && (pstrb[1:0] == 2'h3))
        |=> (pivot_reg[sprite_pivot_pkg::AXIS_X] == $past(pwdata[RW-1:0]));
    endproperty
    a_write_x: assert property (p_write_x) else $error("x offset write lost");

    property p_neg_x;
        (pivot_x[sprite_pivot_pkg::MAG_W-1:0] == pivot_reg[sprite_pivot_pkg::AXIS_X][10:0])
        && ((pivot_x < 0) == pivot_reg[sprite_pivot_pkg::AXIS_X][15]) && (pivot_neg_x == (pivot_x < 0));
    endproperty
    a_neg_x: assert property (p_neg_x) else $error("x sign decode wrong");

    property p_write_y;
        (complete && pwrite && axis_sel[sprite_pivot_pkg::AXIS_Y] && (pstrb[1:0] == 2'h3))
        |=> (pivot_y[sprite_pivot_pkg::MAG_W-1:0] == $past(pwdata[10:0]));
    endproperty
    a_write_y: assert property (p_write_y) else $error("y magnitude write lost");

    property p_neg_y;
        ((pivot_y < 0) == pivot_reg[sprite_pivot_pkg::AXIS_Y][15]) && (pivot_neg_y == (pivot_y < 0));
    endproperty
    a_neg_y: assert property (p_neg_y) else $error("y sign decode wrong");

    // Reset released at an edge is seen by the flops one edge late, so rstn gates the start
    property p_rel;
        (rstn && ce && px_valid) |=> rel_valid && (rel_x == CW'($past(ext_px_x) - $past(ext_piv_x)))
                                       && (rel_y == CW'($past(ext_px_y) - $past(ext_piv_y)));
    endproperty
    a_rel: assert property (p_rel) else $error("pixel not centred on pivot");

    property p_corner;
        (rstn && ce) |=> (corner_x == CW'($past(ref_x) - $past(ext_piv_x)))
            && (corner_y == CW'($past(ref_y) - $past(ext_piv_y)));
    endproperty
    a_corner: assert property (p_corner) else $error("placement not via pivot");

    property p_readback;
        (complete && !pwrite && hit) |-> (prdata == {16'h0000, rd_word});
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_unmapped;
        (psel && penable && data_ready && ce && !hit) |-> pslverr ##1 $stable(pivot_reg);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access misbehaved");

    property p_freeze;
        !ce |=> $stable(pivot_reg) && $stable(rel_x) && $stable(prdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");

    c_write_x:  cover property (wr_take && axis_sel[sprite_pivot_pkg::AXIS_X]);
    c_read_y:   cover property (complete && !pwrite && axis_sel[sprite_pivot_pkg::AXIS_Y]);
    c_unmapped: cover property (pslverr);
    c_neg_rel:  cover property (pivot_neg_x && pivot_neg_y ##1 rel_valid);

endmodule : sprite_reference_point_regs

// file: sim/sprite_reference_point_regs_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module sprite_reference_point_regs_bench;
    typedef struct packed {logic [15:0] wx; logic [15:0] wy; logic [11:0] ex; logic [11:0] ey;} row_s;
    logic                                           core_clk, rstn, ce, psel, penable, pwrite;
    logic                                           pready, pslverr, px_valid, rel_valid, er;
    logic        [sprite_pivot_pkg::ADDR_W-1:0]     paddr;
    logic        [sprite_pivot_pkg::DATA_W-1:0]     pwdata, prdata, rd;
    logic        [sprite_pivot_pkg::STRB_W-1:0]     pstrb;
    logic        [sprite_pivot_pkg::PIX_W-1:0]      px_x, px_y;
    logic signed [sprite_pivot_pkg::COORD_W-1:0]    rel_x, rel_y, ref_x, ref_y, corner_x, corner_y;
    logic signed [sprite_pivot_pkg::OFS_W-1:0]      pivot_x, pivot_y;
    logic                                           pivot_neg_x, pivot_neg_y;
    int                                             bad_count, checked;
    localparam logic [11:0] AX = sprite_pivot_pkg::ADDR_PIVOT_X;
    localparam logic [11:0] AY = sprite_pivot_pkg::ADDR_PIVOT_Y;
    // Bits 14..11 set without bit 15 must still read as positive
    // Written words beside the signed offsets {bit 15, bits 10..0} they should give
    row_s rows [6] = '{'{16'h0000, 16'h07ff, 12'h000, 12'h7ff},
                       '{16'hffff, 16'h8001, 12'hfff, 12'h801},
                       '{16'h7800, 16'hf800, 12'h000, 12'h800},
                       '{16'h8000, 16'h7fff, 12'h800, 12'h7ff},
                       '{16'h0555, 16'h82aa, 12'h555, 12'haaa},
                       '{16'h47ff, 16'hb123, 12'h7ff, 12'h923}};

    sprite_reference_point_regs dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .px_valid(px_valid),
        .px_x(px_x), .px_y(px_y), .rel_valid(rel_valid), .rel_x(rel_x), .rel_y(rel_y),
        .ref_x(ref_x), .ref_y(ref_y), .corner_x(corner_x), .corner_y(corner_y),
        .pivot_x(pivot_x), .pivot_y(pivot_y), .pivot_neg_x(pivot_neg_x),
        .pivot_neg_y(pivot_neg_y));

    function automatic logic signed [13:0] sx(input logic [15:0] w);
        return {{3{w[15]}}, w[10:0]};
    endfunction : sx

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                break;
            end
        end
        if (n == 20) begin
            bad_count++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pstrb = '0; px_valid = 1'b0; px_x = '0; px_y = '0;
        ref_x = 14'sh3f00; ref_y = 14'sh0123;
        bad_count = 0; checked = 0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        apb(1'b0, AX, 16'h0000, 4'h0);
        `CHK(rd, 32'h00000000)
        // --------------------------------------------------------------
        // Table of offsets
        // --------------------------------------------------------------
        foreach (rows[i]) begin
            apb(1'b1, AX, rows[i].wx, 4'hf);
            apb(1'b1, AY, rows[i].wy, 4'hf);
            apb(1'b0, AX, 16'h0000, 4'h0);
            `CHK(rd, {16'h0000, rows[i].wx})
            apb(1'b0, AY, 16'h0000, 4'h0);
            `CHK(rd, {16'h0000, rows[i].wy})
            `CHK(pivot_x, rows[i].ex)
            `CHK(pivot_neg_x, rows[i].wx[15])
            `CHK(pivot_y, rows[i].ey)
            `CHK(pivot_neg_y, rows[i].wy[15])
            px_valid <= 1'b1;
            px_x <= 11'h400;
            px_y <= 11'h7ff;
            @(posedge core_clk);
            px_valid <= 1'b0;
            // rel_valid stands for one cycle only, so look right after the taking edge
            #1;
            `CHK(rel_valid, 1'b1)
            `CHK(rel_x, $signed({3'b000, 11'h400}) - sx(rows[i].wx))
            `CHK(rel_y, $signed({3'b000, 11'h7ff}) - sx(rows[i].wy))
            `CHK(corner_x, ref_x - sx(rows[i].wx))
            `CHK(corner_y, ref_y - sx(rows[i].wy))
            @(posedge core_clk);
            #1;
            `CHK(rel_valid, 1'b0)
        end
        // --------------------------------------------------------------
        // Unmapped address, byte lanes, stalled clock enable
        // --------------------------------------------------------------
        apb(1'b1, AX, 16'h1234, 4'hf);
        apb(1'b1, 12'h054, 16'hffff, 4'hf);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h054, 16'h0000, 4'h0);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        apb(1'b1, AX, 16'habcd, 4'h1);
        apb(1'b1, AX, 16'hffff, 4'hc);
        apb(1'b0, AX, 16'h0000, 4'h0);
        `CHK({er, rd}, {1'b0, 32'h000012cd})
        ce <= 1'b0;
        fork
            apb(1'b0, AX, 16'h0000, 4'h0);
            begin
                repeat (4) @(posedge core_clk);
                ce <= 1'b1;
            end
        join
        `CHK(rd, 32'h000012cd)
        // A second reset in mid-run clears both offsets
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK({pivot_x, pivot_y}, 24'h000000)
        `CHK({corner_x, corner_y}, 28'h0000000)
        `CHK(prdata, 32'h00000000)
        @(posedge core_clk);
        rstn <= 1'b1;
        apb(1'b0, AY, 16'h0000, 4'h0);
        `CHK(rd, 32'h00000000)
        end_of_test();
    end
endmodule : sprite_reference_point_regs_bench
